// >>> bench/smb_bus_model.sv
// Remote SMBus master model that clocks the wires open-drain style.
// Assumes the bench forms wired-AND lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module smb_bus_model (
    input wire logic clk,
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_rel,
    output logic sda_rel
);
    initial
    begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic start();
        @(negedge clk);
        #1 sda_rel = 1'b0;
        #24 scl_rel = 1'b0;
    endtask

    // The high phase is timed from the wire, because the slave may stretch
    // the low phase. All changes land a nanosecond before a sampling edge.
    task automatic clk_bit(input logic v, output logic s);
        @(negedge clk);
        #17 sda_rel = v;
        #4 scl_rel = 1'b1;
        wait (scl_w);
        @(negedge clk);
        #20 s = sda_w;
        #1 scl_rel = 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
    endtask

    task automatic get(output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
    endtask

    // Plays an addressed slave for one byte: each bit changes just after
    // SCL is seen low, and SDA is let go for the ninth clock.
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            wait (!scl_w);
            @(negedge clk);
            #1 sda_rel = b[i];
            wait (scl_w);
        end
        wait (!scl_w);
        @(negedge clk);
        #1 sda_rel = 1'b1;
    endtask

    task automatic stop();
        @(negedge clk);
        #17 sda_rel = 1'b0;
        #4 scl_rel = 1'b1;
        wait (scl_w);
        @(negedge clk);
        #21 sda_rel = 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> bench/smb_seq_tb.sv
// Self-checking bench for the SMBus sequencer.
// Assumes open-drain pins; the pull-ups are formed here.
`timescale 1ns/1ps
`default_nettype none

module smb_seq_tb;
    import smb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [AW-1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic scl_o;
    logic sda_o;
    logic scl_oe_n;
    logic sda_oe_n;
    logic byte_irq;
    logic m_scl;
    logic m_sda;
    wire logic scl_w = scl_oe_n & m_scl;
    wire logic sda_w = sda_oe_n & m_sda;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    smb_seq DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .byte_irq(byte_irq));

    smb_bus_model M (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
        .scl_rel(m_scl), .sda_rel(m_sda));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rdchk(input logic [AW-1:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk8(d, e);
    endtask

    task automatic irq_up();
        for (int k = 0; k < 300 && byte_irq !== 1'b1; k++)
            @(negedge clk);
        chk1(byte_irq, 1'b1);
    endtask

    task automatic irq_quiet();
        logic seen = 1'b0;
        repeat (40)
        begin
            @(negedge clk);
            seen = seen | byte_irq;
        end
        chk1(seen, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_slave_wr();
        logic a;
        wr(ADR_CTRL, 8'h0D);
        M.start();
        M.send(8'h90);
        irq_quiet();
        M.clk_bit(1'b1, a);
        chk1(a, 1'b0);
        irq_up();
        wr(ADR_CTRL, 8'h0D);
        M.send(8'h3C);
        irq_quiet();
        M.clk_bit(1'b1, a);
        chk1(a, 1'b0);
        irq_up();
        rdchk(ADR_DATA, 8'h3C);
        wr(ADR_CTRL, 8'h0D);
        M.stop();
        irq_quiet();
        rdchk(ADR_STAT, 8'h00);
    endtask

    task automatic t_nomatch();
        logic a;
        M.start();
        M.send(8'h92);
        M.clk_bit(1'b1, a);
        chk1(a, 1'b1);
        M.send(8'h55);
        M.clk_bit(1'b1, a);
        irq_quiet();
        M.stop();
    endtask

    task automatic t_manual();
        logic a;
        wr(ADR_CTRL, 8'h01);
        M.start();
        M.send(8'h90);
        irq_up();
        rdchk(ADR_CTRL, 8'hC1);
        wr(ADR_CTRL, 8'h09);
        M.clk_bit(1'b1, a);
        chk1(a, 1'b0);
        M.send(8'hC3);
        irq_up();
        wr(ADR_CTRL, 8'h01);
        M.clk_bit(1'b1, a);
        chk1(a, 1'b1);
        M.stop();
    endtask

    task automatic t_slave_rd();
        logic a;
        logic [7:0] b;
        wr(ADR_CTRL, 8'h0D);
        M.start();
        M.send(8'h91);
        M.clk_bit(1'b1, a);
        chk1(a, 1'b0);
        irq_up();
        wr(ADR_DATA, 8'hA5);
        wr(ADR_CTRL, 8'h0D);
        rdchk(ADR_STAT, 8'h02);
        M.get(b);
        chk8(b, 8'hA5);
        irq_quiet();
        M.clk_bit(1'b1, a);
        irq_up();
        // Top bit high keeps SDA free so the master can still send STOP.
        wr(ADR_DATA, 8'hFF);
        rd(ADR_STAT, b);
        chk1(b[STA_ERR], 1'b1);
        wr(ADR_STAT, 8'h08);
        wr(ADR_CTRL, 8'h0D);
        M.stop();
        irq_quiet();
        rdchk(ADR_STAT, 8'h00);
    endtask

    task automatic t_master_rd();
        logic [7:0] b;
        wr(ADR_CTRL, 8'h01);
        wr(ADR_DATA, 8'h91);
        wr(ADR_CTRL, 8'h11);
        wait (!sda_w);
        chk1(scl_w, 1'b1);
        chk1(scl_o | sda_o, 1'b0);
        for (int i = 7; i >= 0; i--)
            @(posedge scl_w) b[i] = sda_w;
        chk8(b, 8'h91);
        irq_up();
        rd(ADR_STAT, b);
        chk1(b[0], 1'b1);
        fork
            M.put(8'h5A);
            wr(ADR_CTRL, 8'h05);
        join
        irq_up();
        rdchk(ADR_DATA, 8'h5A);
        wr(ADR_CTRL, 8'h21);
        for (int k = 0; k < 100 && b[0] !== 1'b0; k++)
            rd(ADR_STAT, b);
        chk1(b[0], 1'b0);
        chk1(scl_w & sda_w, 1'b1);
    endtask

    // A hang anywhere ends in the same report as a normal run.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails++;
            print_verdict();
        end
    end

    initial
    begin
        reg_addr <= '0;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        rdchk(ADR_CTRL, 8'h00);
        rdchk(3'h7, 8'h00);
        wr(ADR_SADR, 8'h90);
        wr(ADR_SMSK, 8'hFE);
        rdchk(ADR_SADR, 8'h90);
        t_slave_wr();
        t_nomatch();
        t_manual();
        t_slave_rd();
        t_master_rd();
        print_verdict();
    end
endmodule

`default_nettype wire

// >>> logic/smb_pkg.sv
// Constants, register map and state types of the SMBus sequencer.
// Assumes one 250 MHz system clock; SCL and SDA are asynchronous pins.

package smb_pkg;

    localparam int AW = 3;
    localparam logic [2:0] ADR_CTRL = 3'h0;
    localparam logic [2:0] ADR_DATA = 3'h1;
    localparam logic [2:0] ADR_SADR = 3'h2;
    localparam logic [2:0] ADR_SMSK = 3'h3;
    localparam logic [2:0] ADR_STAT = 3'h4;

    localparam int CTL_EN = 0;
    localparam int CTL_INHIBIT = 1;
    localparam int CTL_AUTO = 2;
    localparam int CTL_ACK = 3;
    localparam int CTL_STA = 4;
    localparam int CTL_STOP = 5;
    localparam int CTL_SI = 6;
    localparam int STA_ERR = 3;

    localparam int CLK_PS = 4000;
    localparam int SCL_HALF_NS = 40;
    localparam logic [7:0] HALF_CYC =
        8'((SCL_HALF_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [3:0] BIT_PRE = 4'hF;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_MSTART = 5'h02,
        ST_XFER = 5'h04,
        ST_WAIT = 5'h08,
        ST_MSTOP = 5'h10
    } smb_state_t;

    typedef struct packed {
        smb_state_t st;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic scl_p;
        logic sda_p;
        logic en;
        logic inhibit;
        logic auto_ack;
        logic ack_val;
        logic sta_req;
        logic stop_req;
        logic si;
        logic ack_req;
        logic err;
        logic master;
        logic tx;
        logic addr;
        logic ignore;
        logic acked;
        logic ack_got;
        logic wr_pend;
        logic [7:0] data;
        logic [7:0] sh;
        logic [6:0] sadr;
        logic [6:0] smsk;
        logic [3:0] bitc;
        logic [7:0] cnt;
        logic scl_oe_n;
        logic sda_oe_n;
        logic pin_lvl;
        logic [7:0] rdata;
    } smb_regs_t;

    localparam smb_regs_t REGS_RST = '{
        st: ST_IDLE,
        scl_s: 3'h7,
        sda_s: 3'h7,
        scl_f: 1'b1,
        sda_f: 1'b1,
        scl_p: 1'b1,
        sda_p: 1'b1,
        scl_oe_n: 1'b1,
        sda_oe_n: 1'b1,
        default: '0
    };

endpackage

// >>> logic/smb_seq.sv
// SMBus master (transmit and receive) and slave sequencer with its register port.
// Assumes open-drain pads outside: a low enable pulls the wire low.
`timescale 1ns/1ps
`default_nettype none

module smb_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic [smb_pkg::AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic byte_irq
);
    import smb_pkg::*;

    smb_regs_t q;
    smb_regs_t d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic data_wr;

    function automatic logic addr_hit(
        input logic [7:0] b,
        input logic [6:0] a,
        input logic [6:0] m
    );
        return ((b[7:1] ^ a) & m) == 7'h00;
    endfunction

    assign scl_rise = q.scl_f & ~q.scl_p;
    assign scl_fall = ~q.scl_f & q.scl_p;
    assign bus_start = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
    assign bus_stop = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;
    assign data_wr = reg_wr && (reg_addr == ADR_DATA);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic nb;
        logic a;
        nb = 1'b0;
        a = 1'b0;
        d = q;
        // A pin level counts only once the second and third stages agree.
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        if (q.scl_s[1] == q.scl_s[2])
            d.scl_f = q.scl_s[2];
        if (q.sda_s[1] == q.sda_s[2])
            d.sda_f = q.sda_s[2];
        d.scl_p = q.scl_f;
        d.sda_p = q.sda_f;
        d.cnt = q.cnt + 8'h01;

        // Software accesses first, so that hardware sets below win.
        d.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADR_CTRL: d.rdata = {q.ack_req, q.si, q.stop_req, q.sta_req,
                                     q.ack_val, q.auto_ack, q.inhibit,
                                     q.en};
                ADR_DATA: d.rdata = q.data;
                ADR_SADR: d.rdata = {q.sadr, 1'b0};
                ADR_SMSK: d.rdata = {q.smsk, 1'b0};
                ADR_STAT: d.rdata = {4'h0, q.err, q.ignore,
                                     q.tx, q.master};
                default: d.rdata = 8'h00;
            endcase
        end
        if (reg_wr)
        begin
            case (reg_addr)
                ADR_CTRL:
                begin
                    d.en = reg_wdata[CTL_EN];
                    d.inhibit = reg_wdata[CTL_INHIBIT];
                    d.auto_ack = reg_wdata[CTL_AUTO];
                    d.ack_val = reg_wdata[CTL_ACK];
                    d.sta_req = q.sta_req | reg_wdata[CTL_STA];
                    d.stop_req = q.stop_req | reg_wdata[CTL_STOP];
                    if (!reg_wdata[CTL_SI])
                    begin
                        d.si = 1'b0;
                        d.ack_req = 1'b0;
                    end
                end
                ADR_DATA:
                begin
                    d.data = reg_wdata;
                    d.wr_pend = 1'b1;
                    // Loading after a NACK while still held is a misuse.
                    if (q.si && q.tx && !q.master && !q.ack_got)
                        d.err = 1'b1;
                end
                ADR_SADR: d.sadr = reg_wdata[7:1];
                ADR_SMSK: d.smsk = reg_wdata[7:1];
                ADR_STAT:
                    if (reg_wdata[STA_ERR])
                        d.err = 1'b0;
                default: ;
            endcase
        end

        if (!q.en)
        begin
            d.st = ST_IDLE;
            d.master = 1'b0;
            d.tx = 1'b0;
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
        end
        else
        begin
            unique case (q.st)
                ST_IDLE:
                begin
                    d.scl_oe_n = 1'b1;
                    d.sda_oe_n = 1'b1;
                    if (bus_start)
                    begin
                        d.st = ST_XFER;
                        d.master = 1'b0;
                        d.tx = 1'b0;
                        d.addr = 1'b1;
                        d.ignore = 1'b0;
                        d.bitc = BIT_PRE;
                    end
                    else if (q.sta_req && q.scl_f && q.sda_f)
                    begin
                        d.st = ST_MSTART;
                        d.sta_req = 1'b0;
                        d.ignore = 1'b0;
                        d.master = 1'b1;
                        d.cnt = 8'h00;
                        d.sda_oe_n = 1'b0;
                    end
                end
                ST_MSTART:
                    if (q.cnt >= HALF_CYC)
                    begin
                        // The address byte is the data register as written;
                        // its low bit set to 1 asks for a read.
                        d.st = ST_XFER;
                        d.scl_oe_n = 1'b0;
                        d.cnt = 8'h00;
                        d.tx = 1'b1;
                        d.addr = 1'b1;
                        d.bitc = BIT_PRE;
                        d.sh = q.data;
                        d.wr_pend = data_wr;
                    end
                ST_XFER:
                begin
                    // Both ends keep SCL low one half period after a hold,
                    // which gives SDA its setup time before release.
                    if (!q.scl_oe_n)
                    begin
                        if (q.cnt >= HALF_CYC)
                        begin
                            d.scl_oe_n = 1'b1;
                            d.cnt = 8'h00;
                        end
                    end
                    else if (q.master)
                    begin
                        if (!q.scl_f)
                            d.cnt = 8'h00;
                        else if (q.cnt >= HALF_CYC)
                        begin
                            d.scl_oe_n = 1'b0;
                            d.cnt = 8'h00;
                        end
                    end
                    if (!q.master && bus_stop)
                    begin
                        d.st = ST_IDLE;
                        d.tx = 1'b0;
                        d.sda_oe_n = 1'b1;
                        d.scl_oe_n = 1'b1;
                    end
                    else if (!q.master && bus_start)
                    begin
                        d.tx = 1'b0;
                        d.addr = 1'b1;
                        d.bitc = BIT_PRE;
                        d.sda_oe_n = 1'b1;
                    end
                    else if (scl_rise)
                    begin
                        if (q.bitc < BIT_ACK && !q.tx)
                            d.sh = {q.sh[6:0], q.sda_f};
                        else if (q.bitc == BIT_ACK && q.tx)
                            d.ack_got = ~q.sda_f;
                    end
                    else if (scl_fall)
                    begin
                        if (q.bitc == BIT_PRE)
                        begin
                            d.bitc = 4'h0;
                            if (q.tx)
                                d.sda_oe_n = q.sh[7];
                        end
                        else if (q.bitc == BIT_ACK)
                        begin
                            d.sda_oe_n = 1'b1;
                            if (!q.tx && q.addr && !q.acked)
                            begin
                                d.st = ST_IDLE;
                                d.ignore = 1'b1;
                            end
                            else if (q.tx || q.auto_ack)
                            begin
                                d.si = 1'b1;
                                d.st = ST_WAIT;
                                d.scl_oe_n = 1'b0;
                                d.bitc = 4'h0;
                            end
                            else
                                nb = 1'b1;
                        end
                        else if (q.bitc == 4'h7)
                        begin
                            d.bitc = BIT_ACK;
                            if (q.tx)
                                d.sda_oe_n = 1'b1;
                            else
                            begin
                                d.data = q.sh;
                                if (q.addr && q.inhibit)
                                begin
                                    d.st = ST_IDLE;
                                    d.ignore = 1'b1;
                                end
                                else if (q.auto_ack)
                                begin
                                    a = q.addr ? addr_hit(q.sh, q.sadr,
                                                          q.smsk)
                                               : q.ack_val;
                                    d.acked = a;
                                    d.sda_oe_n = ~a;
                                end
                                else
                                begin
                                    d.si = 1'b1;
                                    d.ack_req = 1'b1;
                                    d.st = ST_WAIT;
                                    d.scl_oe_n = 1'b0;
                                end
                            end
                        end
                        else
                        begin
                            d.bitc = q.bitc + 4'h1;
                            if (q.tx)
                            begin
                                d.sh = {q.sh[6:0], 1'b0};
                                d.sda_oe_n = q.sh[6];
                            end
                        end
                    end
                end
                ST_WAIT:
                begin
                    // SCL stays stretched while software owns the byte.
                    d.scl_oe_n = 1'b0;
                    d.cnt = 8'h00;
                    if (!q.master && bus_stop)
                    begin
                        d.st = ST_IDLE;
                        d.tx = 1'b0;
                        d.scl_oe_n = 1'b1;
                        d.sda_oe_n = 1'b1;
                    end
                    else if (!q.si)
                    begin
                        if (q.bitc == BIT_ACK)
                        begin
                            d.st = ST_XFER;
                            d.acked = q.ack_val;
                            d.sda_oe_n = ~q.ack_val;
                        end
                        else
                            nb = 1'b1;
                    end
                end
                ST_MSTOP:
                    if (q.bitc == 4'h0)
                    begin
                        if (q.cnt >= HALF_CYC)
                        begin
                            d.scl_oe_n = 1'b1;
                            d.bitc = 4'h1;
                            d.cnt = 8'h00;
                        end
                    end
                    else if (!q.scl_f)
                        d.cnt = 8'h00;
                    else if (q.cnt >= HALF_CYC)
                    begin
                        d.sda_oe_n = 1'b1;
                        d.st = ST_IDLE;
                        d.master = 1'b0;
                        d.tx = 1'b0;
                        d.stop_req = 1'b0;
                    end
                default: d.st = ST_IDLE;
            endcase
        end

        // Start of the next byte, or STOP for a master with stop_req: direction follows a pending data write.
        if (nb)
        begin
            if (q.master && q.stop_req)
            begin
                d.st = ST_MSTOP;
                d.bitc = 4'h0;
                d.cnt = 8'h00;
                d.scl_oe_n = 1'b0;
                d.sda_oe_n = 1'b0;
            end
            else
            begin
                d.st = ST_XFER;
                d.addr = 1'b0;
                d.tx = q.wr_pend;
                d.wr_pend = data_wr;
                d.bitc = 4'h0;
                d.sh = q.data;
                d.sda_oe_n = q.wr_pend ? q.data[7] : 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= REGS_RST;
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign scl_o = q.pin_lvl;
    assign sda_o = q.pin_lvl;
    assign scl_oe_n = q.scl_oe_n;
    assign sda_oe_n = q.sda_oe_n;
    assign byte_irq = q.si;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_manual_ack_req:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_XFER && scl_fall && q.bitc == 4'h7 && !q.tx
         && !q.auto_ack && !(q.addr && q.inhibit) && !bus_stop)
        |=> (q.si && q.ack_req && q.st == ST_WAIT))
    else $error("manual ack byte did not request ack");

    a_auto_ack_late:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_XFER && scl_fall && q.bitc == 4'h7 && !q.tx
         && q.auto_ack && !q.addr && !q.si)
        |=> (!q.si && q.st == ST_XFER
             && q.sda_oe_n == !$past(q.ack_val)))
    else $error("auto ack interrupt came before ack");

    a_ack_polarity:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_WAIT && q.bitc == BIT_ACK && !q.si
         && !bus_stop)
        |=> (q.st == ST_XFER && q.sda_oe_n == !$past(q.ack_val)))
    else $error("ack value drove wrong level");

    a_tx_irq_after:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_XFER && scl_fall && q.bitc == BIT_ACK
         && q.tx && !bus_stop && !(bus_start && !q.master))
        |=> (q.si && q.st == ST_WAIT))
    else $error("transmit byte missed its interrupt");

    a_slave_stop:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && !q.master && bus_stop
         && (q.st == ST_XFER || q.st == ST_WAIT))
        |=> (q.st == ST_IDLE && !q.tx))
    else $error("slave did not leave on stop");

    a_master_exit:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.master) ##1 (q.en && !q.master)
        |-> ($past(q.st) == ST_MSTOP && $past(q.stop_req)))
    else $error("master mode left without stop");

    a_write_to_tx:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_WAIT && q.bitc == 4'h0 && !q.si
         && q.wr_pend && !(q.master && q.stop_req) && !bus_stop)
        |=> (q.tx && q.st == ST_XFER))
    else $error("data write did not select transmit");

    a_no_write_rx:
    assert property (@(posedge clk) disable iff (rst)
        (q.en && q.st == ST_WAIT && q.bitc == 4'h0 && !q.si
         && !q.wr_pend && !(q.master && q.stop_req) && !bus_stop)
        |=> (!q.tx && q.sda_oe_n))
    else $error("missing data write did not select receive");

    a_ignored_quiet:
    assert property (@(posedge clk) disable iff (rst)
        (q.ignore && !q.si) |=> !q.si)
    else $error("interrupt raised while address ignored");

endmodule

`default_nettype wire
